// ==== adc_powerdown_conversion_sequencer.sv ====
// power-down/reset sequencing, sinc3 decimation and ready/data pin for the converter
//
// Summary of operation
// - while power-down input is held low, stay down and float the data/ready pin
// - power-down stops oscillator and clears control, filter and serial state
// - on release, wait about 1 ms for the oscillator, then convert continuously
// - once oscillator runs, drive data/ready pin high until first valid result
// - after any reset, first result only after the full 24 ms settling time
// - after settling, one new result every 8 ms (125 Hz)
// - a full internal reset happens automatically on power-up
// - result register overwritten at the end of every conversion, even while settling
// - each result is 12 bits from a third-order sinc decimation filter
// - drive data/ready pin low when a new word is placed in the output register
// - if unread, drive pin high before updating the output register
`timescale 1ns/1ps
`default_nettype none
module adc_powerdown_conversion_sequencer
	import adc_seq_pkg::*;
#(
	parameter int OSC_CYC = OSC_START_CYC,
	parameter int PERIOD_CYC = CONV_CYC,
	parameter int DEC = DEC_RATIO,
	parameter logic [1:0] DEV_ID = 2'h0 // arbitrary value
) (
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	input wire logic powerdown_reset_n_i,
	input wire logic sclk_i,
	input wire logic mod_bit_i,
	output logic dout_rdy_o,
	output logic dout_rdy_oe_o,
	output logic buf_ready_o
);
	localparam int SAMP_CYC = PERIOD_CYC / DEC;
	localparam int SH = 3 * $clog2(DEC) - RES_BITS;
	localparam int W = 3 * $clog2(DEC) + 1;
	localparam int OW = $clog2(OSC_CYC + 1);
	localparam int PW = $clog2(PERIOD_CYC);
	localparam int SW = $clog2(SAMP_CYC + 1);
	localparam logic [OW-1:0] OSC_LAST = OW'(OSC_CYC - 1);
	localparam logic [PW-1:0] PERIOD_LAST = PW'(PERIOD_CYC - 1);
	localparam logic [SW-1:0] SAMP_LAST = SW'(SAMP_CYC - 1);
	localparam logic [1:0] PULSE_LAST = 2'(PULSE_CYC - 1);
	localparam logic [1:0] SETTLE_LAST = 2'(SETTLE_CONV - 1);

	if (PERIOD_CYC % DEC != 0 || SAMP_CYC < 1 || SH < 0 || OSC_CYC < 2) begin : g_chk
		$error("sequencer parameters cannot be served");
	end

	function automatic logic [23:0] make_word(input conv_word_t w);
		make_word = {w.code, PAD_ZEROS, 1'b0, 1'b0, w.err, DEV_ID, STATUS_PAT};
	endfunction : make_word

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic pd_s1, pd_s2, sck_s1, sck_s2, sck_s3;
	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			pd_s1 <= 1'b0;
			pd_s2 <= 1'b0;
			sck_s1 <= 1'b1;
			sck_s2 <= 1'b1;
			sck_s3 <= 1'b1;
		end else begin
			pd_s1 <= powerdown_reset_n_i;
			pd_s2 <= pd_s1;
			sck_s1 <= sclk_i;
			sck_s2 <= sck_s1;
			sck_s3 <= sck_s2;
		end
	end
	logic sclk_fall, sclk_rise;
	assign sclk_fall = sck_s3 & ~sck_s2;
	assign sclk_rise = ~sck_s3 & sck_s2;

	// ------------------------------------------------------------
	// sequencer and sinc3 filter
	// ------------------------------------------------------------
	seq_state_t state, next_state;
	logic [1:0] low_cnt, next_low_cnt, conv_cnt, next_conv_cnt;
	logic [OW-1:0] osc_cnt, next_osc_cnt;
	logic [PW-1:0] period_cnt, next_period_cnt;
	logic [SW-1:0] samp_cnt, next_samp_cnt;
	logic [W-1:0] i1, i2, i3, d1, d2, d3, c1, c2, c3;
	logic [W-1:0] next_i1, next_i2, next_i3, next_d1, next_d2, next_d3;
	conv_word_t result_q, next_result, fresh;
	logic conv_end, samp, push_req;

	always_comb begin
		next_state = state;
		next_low_cnt = pd_s2 ? 2'h0 : (low_cnt == PULSE_LAST ? low_cnt : low_cnt + 2'h1);
		next_osc_cnt = osc_cnt;
		next_period_cnt = period_cnt;
		next_samp_cnt = samp_cnt;
		next_conv_cnt = conv_cnt;
		{next_i1, next_i2, next_i3} = {i1, i2, i3};
		{next_d1, next_d2, next_d3} = {d1, d2, d3};
		next_result = result_q;
		samp = (state == ST_RUN) && (samp_cnt == SAMP_LAST);
		conv_end = (state == ST_RUN) && (period_cnt == PERIOD_LAST);
		c1 = i3 - d1;
		c2 = c1 - d2;
		c3 = c2 - d3;
		fresh.err = |c3[W-1:SH+RES_BITS];
		fresh.code = fresh.err ? {RES_BITS{1'b1}} : c3[SH+RES_BITS-1:SH];
		push_req = conv_end && (conv_cnt == SETTLE_LAST);
		unique case (state)
			ST_DOWN: begin
				if (pd_s2) begin
					next_state = ST_OSC;
				end
			end
			ST_OSC: begin
				next_osc_cnt = osc_cnt + OW'(1);
				if (osc_cnt == OSC_LAST) begin
					next_state = ST_RUN;
				end
			end
			ST_RUN: begin
				// free-running on the system clock; serial activity never moves it
				next_period_cnt = conv_end ? '0 : period_cnt + PW'(1);
				next_samp_cnt = samp ? '0 : samp_cnt + SW'(1);
				if (samp) begin
					next_i1 = i1 + W'(mod_bit_i);
					next_i2 = i2 + i1;
					next_i3 = i3 + i2;
				end
				if (conv_end) begin
					{next_d1, next_d2, next_d3} = {i3, c1, c2};
					next_result = fresh;
					if (conv_cnt != SETTLE_LAST) begin
						next_conv_cnt = conv_cnt + 2'h1;
					end
				end
			end
		endcase
		if (!pd_s2 && low_cnt == PULSE_LAST) begin
			// low for the whole minimum pulse: full power-down clear
			next_state = ST_DOWN;
		end
		if (next_state == ST_DOWN) begin
			next_osc_cnt = '0;
			next_period_cnt = '0;
			next_samp_cnt = '0;
			next_conv_cnt = 2'h0;
			{next_i1, next_i2, next_i3, next_d1, next_d2, next_d3} = '0;
			next_result = '0;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			state <= ST_DOWN;
			low_cnt <= 2'h0;
			osc_cnt <= '0;
			period_cnt <= '0;
			samp_cnt <= '0;
			conv_cnt <= 2'h0;
			{i1, i2, i3, d1, d2, d3} <= '0;
			result_q <= '0;
		end else begin
			state <= next_state;
			low_cnt <= next_low_cnt;
			osc_cnt <= next_osc_cnt;
			period_cnt <= next_period_cnt;
			samp_cnt <= next_samp_cnt;
			conv_cnt <= next_conv_cnt;
			{i1, i2, i3, d1, d2, d3} <= {next_i1, next_i2, next_i3, next_d1, next_d2, next_d3};
			result_q <= next_result;
		end
	end

	// ------------------------------------------------------------
	// two-entry buffer between filter and output register
	// ------------------------------------------------------------
	conv_word_t mem [2];
	logic wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr, pop, push, buf_ready, next_buf_ready;
	logic [1:0] cnt, next_cnt;
	logic fifo_valid;
	assign fifo_valid = (cnt != 2'h0);
	// a word arriving while both entries wait on a slow reader is dropped
	assign push = push_req && buf_ready;

	always_comb begin
		next_wr_ptr = wr_ptr ^ push;
		next_rd_ptr = rd_ptr ^ pop;
		next_cnt = cnt + 2'(push) - 2'(pop);
		// also cleared on the way into power-down, so nothing survives the drop
		if (state != ST_RUN || next_state == ST_DOWN) begin
			next_wr_ptr = 1'b0;
			next_rd_ptr = 1'b0;
			next_cnt = 2'h0;
		end
		next_buf_ready = (next_cnt != FIFO_DEPTH);
	end

	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			cnt <= 2'h0;
			buf_ready <= 1'b1;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			cnt <= next_cnt;
			buf_ready <= next_buf_ready;
		end
		if (push) begin
			mem[wr_ptr] <= fresh;
		end
	end

	// ------------------------------------------------------------
	// data/ready pin and output shift register
	// ------------------------------------------------------------
	logic dout, oe, loaded, busy, gap;
	logic next_dout, next_oe, next_loaded, next_busy, next_gap;
	logic [23:0] shift, next_shift;
	logic [4:0] bit_cnt, next_bit_cnt;

	always_comb begin
		next_dout = dout;
		next_oe = 1'b1;
		next_loaded = loaded;
		next_busy = busy;
		next_gap = gap;
		next_shift = shift;
		next_bit_cnt = bit_cnt;
		pop = 1'b0;
		if (state != ST_RUN) begin
			next_oe = 1'b0;
			next_dout = 1'b1;
			next_loaded = 1'b0;
			next_busy = 1'b0;
			next_gap = 1'b0;
			next_bit_cnt = 5'h0;
		end else if (busy && bit_cnt == WORD_BITS) begin
			if (sclk_rise) begin
				next_dout = 1'b1; // word read once, pin back high
				next_busy = 1'b0;
				next_bit_cnt = 5'h0;
			end
		end else if (sclk_fall && (loaded || busy)) begin
			next_dout = shift[23];
			next_shift = {shift[22:0], 1'b0};
			next_bit_cnt = bit_cnt + 5'h1;
			next_busy = 1'b1;
			next_loaded = 1'b0;
			next_gap = 1'b0;
		end else if (!busy && fifo_valid) begin
			if (loaded && !gap) begin
				next_gap = 1'b1;
				next_dout = 1'b1;
			end else begin
				next_shift = make_word(mem[rd_ptr]);
				pop = 1'b1;
				next_loaded = 1'b1;
				next_gap = 1'b0;
				next_dout = 1'b0;
				next_bit_cnt = 5'h0;
			end
		end else if (!loaded && !busy) begin
			next_dout = 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			dout <= 1'b1;
			oe <= 1'b0;
			loaded <= 1'b0;
			busy <= 1'b0;
			gap <= 1'b0;
			shift <= 24'h00_0000;
			bit_cnt <= 5'h0;
		end else begin
			dout <= next_dout;
			oe <= next_oe;
			loaded <= next_loaded;
			busy <= next_busy;
			gap <= next_gap;
			shift <= next_shift;
			bit_cnt <= next_bit_cnt;
		end
	end

	assign dout_rdy_o = dout;
	assign dout_rdy_oe_o = oe;
	assign buf_ready_o = buf_ready;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!reset_n_i);

	sequence s_park;
		loaded && !busy && !gap && fifo_valid && !sclk_fall;
	endsequence
	sequence s_high_then_low;
		dout_rdy_o ##1 !dout_rdy_o;
	endsequence

	a_down_float: assert property (state == ST_DOWN |=> !dout_rdy_oe_o)
		else $error("pin driven while powered down");
	a_down_clear: assert property (state == ST_DOWN |-> i3 == '0 && cnt == 2'h0 && conv_cnt == 2'h0)
		else $error("filter or buffer state kept through power-down");
	a_pulse_down: assert property (!pd_s2 [*3] |=> state == ST_DOWN)
		else $error("minimum power-down pulse not honoured");
	a_osc_wait: assert property (state == ST_OSC && osc_cnt == OSC_LAST |=> state == ST_RUN)
		else $error("oscillator start time wrong");
	a_run_high: assert property ($rose(state == ST_RUN) |=> dout_rdy_oe_o && dout_rdy_o)
		else $error("pin not driven high after start-up");
	a_first_settle: assert property (push |-> conv_cnt == SETTLE_LAST)
		else $error("result released before settling");
	a_conv_rate: assert property (conv_end |=> period_cnt == '0 ##1 period_cnt == PW'(1))
		else $error("conversion period counter off");
	a_result_upd: assert property (conv_end && !$past(state == ST_DOWN) |=> result_q == $past(fresh))
		else $error("result register not updated");
	a_load_low: assert property (pop |=> !dout_rdy_o && loaded)
		else $error("pin not low after a new word");
	a_gap_high: assert property (s_park |=> s_high_then_low)
		else $error("no high gap before overwrite");
endmodule : adc_powerdown_conversion_sequencer
`default_nettype wire

// ==== adc_powerdown_conversion_sequencer_bench.sv ====
// self-checking bench for the power-down and conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module adc_powerdown_conversion_sequencer_bench;
	import adc_seq_pkg::*;
	localparam int PER = 400;
	logic clk_sys_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic powerdown_reset_n_i = 1'b0;
	logic mod_bit_i = 1'b0;
	logic last = 1'b1;
	logic dout_rdy_o;
	logic dout_rdy_oe_o;
	logic buf_ready_o;
	wire logic sclk;
	wire logic pin;
	logic [23:0] word;
	int mismatches = 0;
	int checked = 0;
	int cyc = 0;
	int n;
	int t0;

	always #20 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i) begin
		cyc++;
		mod_bit_i <= ~mod_bit_i;
		if (dout_rdy_oe_o === 1'b1) last <= dout_rdy_o;
	end
	// a released pin must not look like its last driven level
	assign pin = (dout_rdy_oe_o === 1'b1) ? dout_rdy_o : ~last;

	adc_powerdown_conversion_sequencer #(.OSC_CYC(20), .PERIOD_CYC(PER), .DEC(16)) uut (
		.clk_sys_i(clk_sys_i),
		.reset_n_i(reset_n_i),
		.powerdown_reset_n_i(powerdown_reset_n_i),
		.sclk_i(sclk),
		.mod_bit_i(mod_bit_i),
		.dout_rdy_o(dout_rdy_o),
		.dout_rdy_oe_o(dout_rdy_oe_o),
		.buf_ready_o(buf_ready_o)
	);
	host_reader host (.pin_i(pin), .sclk_o(sclk));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : check
	task automatic cycles(input int k);
		repeat (k) @(posedge clk_sys_i);
		#1;
	endtask : cycles
	task automatic wait_for(input logic lvl, input int lim, output int k);
		k = 0;
		while (dout_rdy_o !== lvl && k < lim) begin
			cycles(1);
			k++;
		end
	endtask : wait_for
	task automatic conclude();
		$display("checked %0d, mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : conclude

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic test_power_up();
		@(posedge clk_sys_i) powerdown_reset_n_i <= 1'b1;
		cycles(10);
		check("oe during oscillator start", 1'b0, dout_rdy_oe_o);
		n = 0;
		while (dout_rdy_oe_o !== 1'b1 && n < 40) begin
			cycles(1);
			n++;
		end
		check("oe after oscillator start", 1'b1, dout_rdy_oe_o);
		check("pin high before first word", 1'b1, dout_rdy_o);
		wait_for(1'b0, 3 * PER + 20, n);
		check("settled first word delay", 1'b1, n >= 3 * PER - 4 && n <= 3 * PER + 4);
		t0 = cyc;
		$display("test power up done");
	endtask : test_power_up

	task automatic test_read();
		host.read_word(word);
		check("zero pad bits", 4'h0, word[11:8]);
		check("status bits", {2'b00, 1'b0, 2'b00, STATUS_PAT}, {word[7:6], 1'b0, word[4:0]});
		cycles(8);
		check("pin high after read", 1'b1, dout_rdy_o);
		wait_for(1'b0, PER, n);
		check("result period", PER, cyc - t0);
		t0 = cyc;
		$display("test read done");
	endtask : test_read

	task automatic test_unread();
		wait_for(1'b1, PER + 10, n);
		check("high before update", 1'b1, n >= PER - 4 && n <= PER);
		wait_for(1'b0, 4, n);
		check("overwritten word ready", 1'b0, dout_rdy_o);
		$display("test unread done");
	endtask : test_unread

	task automatic test_powerdown();
		@(posedge clk_sys_i) powerdown_reset_n_i <= 1'b0;
		@(posedge clk_sys_i);
		@(posedge clk_sys_i) powerdown_reset_n_i <= 1'b1;
		cycles(8);
		check("oe after short pulse", 1'b1, dout_rdy_oe_o);
		@(posedge clk_sys_i) powerdown_reset_n_i <= 1'b0;
		cycles(8);
		check("oe in power down", 1'b0, dout_rdy_oe_o);
		check("buffer cleared", 1'b1, buf_ready_o);
		cycles(4);
		$display("test power down done");
		test_power_up();
	endtask : test_powerdown

	// ------------------------------------------------------------
	// main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		cycles(4);
		check("oe in reset", 1'b0, dout_rdy_oe_o);
		cycles(4);
		reset_n_i <= 1'b1;
		test_power_up();
		test_read();
		test_unread();
		test_powerdown();
		conclude();
	end
	initial begin
		cycles(9000);
		mismatches++;
		conclude();
	end
endmodule : adc_powerdown_conversion_sequencer_bench
`default_nettype wire

// ==== adc_seq_pkg.sv ====
// shared constants and types for the converter power-down and conversion sequencer
package adc_seq_pkg;
	// ------------------------------------------------------------
	// timing figures as printed, and their cycle counts
	// ------------------------------------------------------------
	localparam int CLK_MHZ = 25;
	localparam int MIN_PULSE_NS = 100;
	localparam int OSC_START_US = 1000;
	localparam int CONV_PERIOD_US = 8000;
	localparam int SETTLE_US = 24000;
	// least time: round up
	localparam int PULSE_CYC = (MIN_PULSE_NS * CLK_MHZ + 999) / 1000;
	localparam int OSC_START_CYC = OSC_START_US * CLK_MHZ;
	localparam int CONV_CYC = CONV_PERIOD_US * CLK_MHZ;
	localparam int SETTLE_CONV = SETTLE_US / CONV_PERIOD_US;
	localparam int DEC_RATIO = 250;

	// ------------------------------------------------------------
	// result word layout
	// ------------------------------------------------------------
	localparam int RES_BITS = 12;
	localparam logic [4:0] WORD_BITS = 5'h18;
	localparam logic [3:0] PAD_ZEROS = 4'h0;
	localparam logic [2:0] STATUS_PAT = 3'h5;
	localparam logic [1:0] FIFO_DEPTH = 2'h2;

	typedef enum logic [1:0] {
		ST_DOWN,
		ST_OSC,
		ST_RUN
	} seq_state_t;

	typedef struct packed {
		logic [RES_BITS-1:0] code;
		logic err;
	} conv_word_t;
endpackage : adc_seq_pkg

// ==== host_reader.sv ====
// host model that clocks one result word out of the data/ready pin
`timescale 1ns/1ps
`default_nettype none
module host_reader (
	input wire logic pin_i,
	output logic sclk_o
);
	// ------------------------------------------------------------
	// serial read
	// ------------------------------------------------------------
	initial sclk_o = 1'b1;
	// clock stands high between frames; each bit is taken just before the rising edge,
	// since the pin returns high soon after the rise that follows the last bit
	task automatic read_word(output logic [23:0] w);
		for (int i = 23; i >= 0; i--) begin
			sclk_o = 1'b0;
			#150;
			w[i] = pin_i;
			#10;
			sclk_o = 1'b1;
			#160;
		end
	endtask : read_word
endmodule : host_reader
`default_nettype wire
